// File: rtl/flash_access_guard.sv
// Flash access guard: routes core data writes, code reads and debug accesses
// to the flash array, applies software enables and the lock byte, and times
// the read strobe.
// Assumes the flash array returns data during the last strobe cycle and
// performs its own erase/write timing from the extended-time select.
`timescale 1ns/10ps

// Functional notes
// - Flash stores run-time data besides code
// - Data writes go to flash when enabled
// - Data-space reads always go to RAM
// - Core modification only with store write enable
// - Core erase needs write and erase enables
// - Lock byte guards unprotected code, debug
// - Locked pages run from page zero
// - Locked count is inverted lock byte
// - Lock byte page locked unless all ones
// - Read-time bit picks one or two clocks
// - Erase/write time bit picks short/extended
module flash_access_guard #(
   parameter int ADDR_W = 16,
   parameter logic [ADDR_W-1:0] LOCK_ADDR = '1
) (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic sfr_wr_in,
   input wire logic [7:0] sfr_wdata_in,
   output logic [7:0] sfr_rdata_out,
   input wire logic [ADDR_W-1:0] core_pc_in,
   input wire logic xwr_req_in,
   input wire logic [ADDR_W-1:0] xwr_addr_in,
   input wire logic [7:0] xwr_data_in,
   input wire logic xrd_req_in,
   input wire logic [ADDR_W-1:0] xrd_addr_in,
   input wire logic crd_req_in,
   input wire logic [ADDR_W-1:0] crd_addr_in,
   output logic crd_valid_out,
   output logic [7:0] rd_data_out,
   input wire logic dbg_rd_in,
   input wire logic dbg_wr_in,
   input wire logic dbg_erase_in,
   input wire logic [ADDR_W-1:0] dbg_addr_in,
   input wire logic [7:0] dbg_wdata_in,
   output logic dbg_valid_out,
   output logic ready_out,
   output logic violation_out,
   output logic external_data_ram_rd_out,
   output logic external_data_ram_wr_out,
   output logic [ADDR_W-1:0] external_data_ram_addr_out,
   output logic [7:0] external_data_ram_wdata_out,
   output logic [ADDR_W-1:0] flash_addr_out,
   output logic flash_rd_out,
   output logic flash_wr_out,
   output logic flash_erase_out,
   output logic [7:0] flash_wdata_out,
   input wire logic [7:0] flash_rdata_in,
   output logic flash_ext_time_out,
   output logic [7:0] lock_byte_out
);
   flash_guard_pkg::guard_state_t state;
   flash_guard_pkg::guard_state_t next_state;
   logic [7:0] flash_timing_scale;
   logic [7:0] program_store_control;
   logic [7:0] lock_byte;
   logic booting;
   logic owner_dbg;
   logic long_op;
   logic rd_blocked;

   // Register decode
   wire sel_fts = sfr_addr_in == flash_guard_pkg::SFR_FLASH_TIMING_SCALE;
   wire sel_psc = sfr_addr_in == flash_guard_pkg::SFR_PROGRAM_STORE_CONTROL;
   wire wr_fts = sfr_wr_in && sel_fts;
   wire wr_psc = sfr_wr_in && sel_psc;
   wire [7:0] next_sfr_rdata = sel_fts ? flash_timing_scale :
                               sel_psc ? program_store_control : 8'h00;
   wire store_we = program_store_control[flash_guard_pkg::STORE_WRITE_BIT];
   wire store_ee = program_store_control[flash_guard_pkg::STORE_ERASE_BIT];
   wire read_long = flash_timing_scale[flash_guard_pkg::READ_STROBE_BIT];

   // Request arbitration: debug, then data write, then code read
   wire idle = state == flash_guard_pkg::ST_IDLE;
   wire dbg_any = dbg_rd_in || dbg_wr_in || dbg_erase_in;
   wire take_dbg = idle && dbg_any;
   wire take_xwr = idle && !dbg_any && xwr_req_in;
   wire take_crd = idle && !dbg_any && !xwr_req_in && crd_req_in;
   wire [ADDR_W-1:0] sel_addr = dbg_any ? dbg_addr_in :
                                xwr_req_in ? xwr_addr_in : crd_addr_in;

   logic tgt_locked;
   logic pc_locked;
   page_lock_check #(.ADDR_W(ADDR_W)) u_tgt_check (
      .lock_byte_in(lock_byte),
      .lock_addr_in(LOCK_ADDR),
      .addr_in(sel_addr),
      .locked_out(tgt_locked)
   );
   page_lock_check #(.ADDR_W(ADDR_W)) u_pc_check (
      .lock_byte_in(lock_byte),
      .lock_addr_in(LOCK_ADDR),
      .addr_in(core_pc_in),
      .locked_out(pc_locked)
   );

   // Code running from a locked page is protected; debug never is
   wire allowed = dbg_any ? !tgt_locked : (pc_locked || !tgt_locked);

   // Data writes reach flash only with the store enable set
   wire xwr_flash = take_xwr && store_we;
   wire xwr_ram = take_xwr && !store_we;
   wire core_erase = xwr_flash && store_ee;
   wire dbg_erase = take_dbg && !dbg_rd_in && dbg_erase_in;
   wire dbg_write = take_dbg && !dbg_rd_in && !dbg_erase_in && dbg_wr_in;
   wire want_erase = core_erase || dbg_erase;
   wire want_write = (xwr_flash && !store_ee) || dbg_write;
   wire fire_erase = want_erase && allowed;
   wire fire_write = want_write && allowed;
   wire next_violation = (want_erase || want_write) && !allowed;
   wire [7:0] wr_byte = dbg_any ? dbg_wdata_in : xwr_data_in;

   wire take_rd = take_crd || (take_dbg && dbg_rd_in);
   wire rd_last = (state == flash_guard_pkg::ST_RD1 && !long_op) ||
                  state == flash_guard_pkg::ST_RD2;
   wire [7:0] rd_value = rd_blocked ? flash_guard_pkg::READ_BLOCKED_DATA : flash_rdata_in;

   wire lock_hit_wr = fire_write && sel_addr == LOCK_ADDR;
   wire lock_hit_er = fire_erase &&
      (sel_addr >> flash_guard_pkg::PAGE_SHIFT) == (LOCK_ADDR >> flash_guard_pkg::PAGE_SHIFT);

   always_comb begin
      next_state = state;
      case (state)
         flash_guard_pkg::ST_BOOT: next_state = flash_guard_pkg::ST_RD1;
         flash_guard_pkg::ST_IDLE: begin
            if (take_rd) begin
               next_state = flash_guard_pkg::ST_RD1;
            end
         end
         flash_guard_pkg::ST_RD1: begin
            next_state = long_op ? flash_guard_pkg::ST_RD2 : flash_guard_pkg::ST_IDLE;
         end
         flash_guard_pkg::ST_RD2: next_state = flash_guard_pkg::ST_IDLE;
         default: next_state = flash_guard_pkg::ST_BOOT;
      endcase
   end

   wire next_strobe = next_state == flash_guard_pkg::ST_RD1 ||
                      next_state == flash_guard_pkg::ST_RD2;

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         state <= flash_guard_pkg::ST_BOOT;
         flash_timing_scale <= flash_guard_pkg::FLASH_TIMING_SCALE_RESET;
         program_store_control <= flash_guard_pkg::PROGRAM_STORE_CONTROL_RESET;
         sfr_rdata_out <= 8'h00;
         ready_out <= 1'b0;
      end else if (clk_en_in) begin
         state <= next_state;
         sfr_rdata_out <= next_sfr_rdata;
         ready_out <= next_state == flash_guard_pkg::ST_IDLE;
         if (wr_fts) begin
            flash_timing_scale <= sfr_wdata_in;
         end
         if (wr_psc) begin
            program_store_control <= sfr_wdata_in;
         end
      end
   end

   // Read sequencing, including the lock byte fetch after reset
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         booting <= 1'b1;
         owner_dbg <= 1'b0;
         long_op <= 1'b1;
         rd_blocked <= 1'b0;
         flash_rd_out <= 1'b0;
         flash_addr_out <= '0;
         crd_valid_out <= 1'b0;
         dbg_valid_out <= 1'b0;
         rd_data_out <= 8'h00;
      end else if (clk_en_in) begin
         flash_rd_out <= next_strobe;
         crd_valid_out <= rd_last && !booting && !owner_dbg;
         dbg_valid_out <= rd_last && !booting && owner_dbg;
         if (state == flash_guard_pkg::ST_BOOT) begin
            flash_addr_out <= LOCK_ADDR;
            long_op <= 1'b1;
            rd_blocked <= 1'b0;
         end else if (take_rd) begin
            flash_addr_out <= sel_addr;
            owner_dbg <= dbg_any;
            long_op <= read_long;
            rd_blocked <= !allowed;
         end else if (fire_write || fire_erase) begin
            flash_addr_out <= sel_addr;
         end
         if (rd_last) begin
            booting <= 1'b0;
            if (!booting) begin
               rd_data_out <= rd_value;
            end
         end
      end
   end

   // Program/erase strobes and lock byte tracking
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         lock_byte <= flash_guard_pkg::LOCK_BYTE_ERASED;
         flash_wr_out <= 1'b0;
         flash_erase_out <= 1'b0;
         flash_wdata_out <= 8'h00;
         violation_out <= 1'b0;
      end else if (clk_en_in) begin
         flash_wr_out <= fire_write;
         flash_erase_out <= fire_erase;
         violation_out <= next_violation;
         if (fire_write) begin
            flash_wdata_out <= wr_byte;
         end
         if (rd_last && booting) begin
            lock_byte <= flash_rdata_in;
         end else if (lock_hit_er) begin
            lock_byte <= flash_guard_pkg::LOCK_BYTE_ERASED;
         end else if (lock_hit_wr) begin
            lock_byte <= lock_byte & wr_byte;
         end
      end
   end

   // Data-space path to on-chip RAM; reads always, writes only with store write enable clear
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         external_data_ram_rd_out <= 1'b0;
         external_data_ram_wr_out <= 1'b0;
         external_data_ram_addr_out <= '0;
         external_data_ram_wdata_out <= 8'h00;
      end else if (clk_en_in) begin
         external_data_ram_rd_out <= xrd_req_in;
         external_data_ram_wr_out <= xwr_ram;
         if (xrd_req_in) begin
            external_data_ram_addr_out <= xrd_addr_in;
         end else if (xwr_ram) begin
            external_data_ram_addr_out <= xwr_addr_in;
            external_data_ram_wdata_out <= xwr_data_in;
         end
      end
   end

   assign flash_ext_time_out = flash_timing_scale[flash_guard_pkg::ERASE_WRITE_TIME_BIT];
   assign lock_byte_out = lock_byte;

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);

   a_write_needs_enable: assert property (
      clk_en_in && take_xwr && !store_we |=> !flash_wr_out && !flash_erase_out && external_data_ram_wr_out)
      else $error("flash modified without store write enable");
   a_erase_needs_both: assert property (
      clk_en_in && take_xwr && store_we && !store_ee |=> !flash_erase_out)
      else $error("erase without erase enable");
   a_write_routed: assert property (
      clk_en_in && xwr_flash && !store_ee && allowed |=> flash_wr_out && !external_data_ram_wr_out)
      else $error("enabled data write not routed to flash");
   a_external_data_ram_read_route: assert property (
      clk_en_in && xrd_req_in |=> external_data_ram_rd_out && external_data_ram_addr_out == $past(xrd_addr_in))
      else $error("data-space read not sent to RAM");
   a_short_strobe: assert property (
      clk_en_in && state == flash_guard_pkg::ST_RD1 && !long_op && !take_rd |=> !flash_rd_out)
      else $error("short read strobe too long");
   a_long_strobe: assert property (
      clk_en_in && state == flash_guard_pkg::ST_RD1 && long_op |=> flash_rd_out ##0
      state == flash_guard_pkg::ST_RD2)
      else $error("long read strobe not two cycles");
   a_locked_blocked: assert property (
      clk_en_in && want_write && !allowed |=> violation_out && !flash_wr_out)
      else $error("write into locked page not blocked");
   a_page_zero_lock: assert property (
      lock_byte != 8'hFF && sel_addr < ADDR_W'(flash_guard_pkg::PAGE_BYTES) |-> tgt_locked)
      else $error("page zero not locked");
   a_all_ones_open: assert property (
      lock_byte == 8'hFF |-> !tgt_locked && !pc_locked)
      else $error("page locked with erased lock byte");
   a_ext_time_follow: assert property (
      clk_en_in && wr_fts |=> flash_ext_time_out == $past(sfr_wdata_in[1]))
      else $error("extended time select not updated");
   a_blocked_read_zero: assert property (
      clk_en_in && rd_last && !booting && rd_blocked |=> rd_data_out == 8'h00)
      else $error("blocked read returned flash data");
   a_data_read_no_flash: assert property (
      clk_en_in && idle && xrd_req_in && !dbg_any && !xwr_req_in && !crd_req_in |=> !flash_rd_out)
      else $error("data-space read strobed the flash");

   c_core_read: cover property (clk_en_in && crd_valid_out);
   c_long_debug_read: cover property (dbg_valid_out && long_op);
   c_erase_done: cover property (flash_erase_out);
   c_violation: cover property (violation_out);
endmodule

// File: rtl/flash_guard_pkg.sv
// Shared constants for the flash access guard: register map, field positions,
// reset values and controller state codes.
// Assumes the core's special-register port carries 8-bit addresses and data.
package flash_guard_pkg;
   localparam logic [7:0] SFR_FLASH_TIMING_SCALE = 8'hB6;
   localparam logic [7:0] SFR_PROGRAM_STORE_CONTROL = 8'h8F;
   localparam logic [7:0] FLASH_TIMING_SCALE_RESET = 8'h00;
   localparam logic [7:0] PROGRAM_STORE_CONTROL_RESET = 8'h00;
   localparam int READ_STROBE_BIT = 4;
   localparam int ERASE_WRITE_TIME_BIT = 1;
   localparam int STORE_WRITE_BIT = 0;
   localparam int STORE_ERASE_BIT = 1;
   localparam int PAGE_BYTES = 512;
   localparam int PAGE_SHIFT = $clog2(PAGE_BYTES);
   localparam logic [7:0] LOCK_BYTE_ERASED = 8'hFF;
   localparam logic [7:0] READ_BLOCKED_DATA = 8'h00;

   typedef enum logic [3:0] {
      ST_BOOT = 4'h1,
      ST_IDLE = 4'h2,
      ST_RD1 = 4'h4,
      ST_RD2 = 4'h8
   } guard_state_t;
endpackage

// File: rtl/page_lock_check.sv
// Decides whether a flash address falls in a page locked by the lock byte.
// Purely combinational; assumes pages of flash_guard_pkg::PAGE_BYTES.
`timescale 1ns/10ps
module page_lock_check #(
   parameter int ADDR_W = 16
) (
   input wire logic [7:0] lock_byte_in,
   input wire logic [ADDR_W-1:0] lock_addr_in,
   input wire logic [ADDR_W-1:0] addr_in,
   output logic locked_out
);
   wire [15:0] page_num = 16'(addr_in >> flash_guard_pkg::PAGE_SHIFT);
   wire [15:0] lock_page = 16'(lock_addr_in >> flash_guard_pkg::PAGE_SHIFT);
   // Locked run starts at page zero, length is the inverted lock byte
   wire [15:0] locked_count = {8'h00, ~lock_byte_in};
   wire any_locked = lock_byte_in != flash_guard_pkg::LOCK_BYTE_ERASED;

   assign locked_out = (page_num < locked_count) ||
                       (any_locked && page_num == lock_page);
endmodule

// File: verif/flash_array_model.sv
// Behavioural flash array behind the guard: byte store, bit-clearing program
// and 512-byte page erase. Assumes the guard holds the read strobe throughout.
`timescale 1ns/10ps
module flash_array_model #(
   parameter logic [7:0] LOCK_INIT = 8'hFD
) (
   input wire logic sys_clk_in,
   input wire logic [15:0] flash_addr_in,
   input wire logic flash_rd_in,
   input wire logic flash_wr_in,
   input wire logic flash_erase_in,
   input wire logic [7:0] flash_wdata_in,
   output logic [7:0] flash_rdata_out
);
   logic [7:0] mem [0:65535];
   logic [7:0] last = 8'h00;
   // Outside a strobe the bus toggles, showing the complement of the previous cycle's value
   assign flash_rdata_out = flash_rd_in ? mem[flash_addr_in] : ~last;
   initial begin
      foreach (mem[i]) begin
         mem[i] = 8'hFF;
      end
      mem[16'hFFFF] = LOCK_INIT;
   end
   always @(posedge sys_clk_in) begin
      last <= flash_rdata_out;
      if (flash_wr_in) begin
         mem[flash_addr_in] <= mem[flash_addr_in] & flash_wdata_in;
      end
      if (flash_erase_in) begin
         for (int i = 0; i < 512; i++) begin
            mem[{flash_addr_in[15:9], 9'h000} + i] <= 8'hFF;
         end
      end
   end
endmodule

// File: verif/flash_access_guard_tb.sv
// Self-checking bench for the flash access guard with a flash array model.
// Assumes lock byte 0xFD at the top address: pages 0, 1 and the last locked.
`timescale 1ns/10ps
module flash_access_guard_tb;
   logic sys_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic clk_en_in = 1'b1;
   logic sfr_wr_in = 1'b0, xwr_req_in = 1'b0, xrd_req_in = 1'b0, crd_req_in = 1'b0;
   logic dbg_rd_in = 1'b0, dbg_wr_in = 1'b0, dbg_erase_in = 1'b0;
   logic [7:0] sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, xwr_data_in = 8'h00;
   logic [7:0] dbg_wdata_in = 8'h00, sfr_rdata_out, rd_data_out, external_data_ram_wdata_out;
   logic [7:0] flash_wdata_out, flash_rdata_in, lock_byte_out;
   logic [15:0] core_pc_in = 16'h2000, xwr_addr_in = 16'h0000, xrd_addr_in = 16'h0000;
   logic [15:0] crd_addr_in = 16'h0000, dbg_addr_in = 16'h0000;
   logic [15:0] external_data_ram_addr_out, flash_addr_out;
   logic crd_valid_out, dbg_valid_out, ready_out, violation_out, external_data_ram_rd_out, external_data_ram_wr_out;
   logic flash_rd_out, flash_wr_out, flash_erase_out, flash_ext_time_out;
   int n_fail = 0;
   int total_checks = 0;

   always #5 sys_clk_in = ~sys_clk_in;

   flash_access_guard #(.ADDR_W(16)) i_flash_access_guard (.sys_clk_in, .rst_n_in,
      .clk_en_in, .sfr_addr_in, .sfr_wr_in, .sfr_wdata_in, .sfr_rdata_out, .core_pc_in,
      .xwr_req_in, .xwr_addr_in, .xwr_data_in, .xrd_req_in, .xrd_addr_in, .crd_req_in,
      .crd_addr_in, .crd_valid_out, .rd_data_out, .dbg_rd_in, .dbg_wr_in, .dbg_erase_in,
      .dbg_addr_in, .dbg_wdata_in, .dbg_valid_out, .ready_out, .violation_out,
      .external_data_ram_rd_out, .external_data_ram_wr_out, .external_data_ram_addr_out, .external_data_ram_wdata_out, .flash_addr_out,
      .flash_rd_out, .flash_wr_out, .flash_erase_out, .flash_wdata_out, .flash_rdata_in,
      .flash_ext_time_out, .lock_byte_out);

   flash_array_model #(.LOCK_INIT(8'hFD)) i_flash_array_model (.sys_clk_in(sys_clk_in),
      .flash_addr_in(flash_addr_out), .flash_rd_in(flash_rd_out),
      .flash_wr_in(flash_wr_out), .flash_erase_in(flash_erase_out),
      .flash_wdata_in(flash_wdata_out), .flash_rdata_out(flash_rdata_in));

   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wait_ready();
      int n = 0;
      while (ready_out !== 1'b1 && n < 20) begin
         @(posedge sys_clk_in);
         #1;
         n++;
      end
      check("ready", ready_out, 16'h0001);
   endtask

   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_in);
      sfr_addr_in <= a;
      sfr_wdata_in <= d;
      sfr_wr_in <= 1'b1;
      @(posedge sys_clk_in);
      sfr_wr_in <= 1'b0;
   endtask

   task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk_in);
      sfr_addr_in <= a;
      @(posedge sys_clk_in);
      #1;
      check("register read", sfr_rdata_out, exp);
   endtask

   // Expected {erase, flash write, ram write, violation}
   task automatic xwrite(input logic [15:0] a, input logic [7:0] d, input logic [3:0] exp);
      wait_ready();
      @(posedge sys_clk_in);
      xwr_req_in <= 1'b1;
      xwr_addr_in <= a;
      xwr_data_in <= d;
      @(posedge sys_clk_in);
      xwr_req_in <= 1'b0;
      #1;
      check("write path", {flash_erase_out, flash_wr_out, external_data_ram_wr_out, violation_out}, exp);
      if (exp[3] || exp[2]) begin
         check("flash addr", flash_addr_out, a);
      end
      if (exp[2]) begin
         check("flash data", flash_wdata_out, d);
      end
      if (exp[1]) begin
         check("ram addr", external_data_ram_addr_out, a);
         check("ram data", external_data_ram_wdata_out, d);
      end
   endtask

   task automatic fread(input logic dbg, input logic [15:0] a, input logic [7:0] exp,
                        input int strobe);
      int n = 0;
      wait_ready();
      @(posedge sys_clk_in);
      dbg_rd_in <= dbg;
      crd_req_in <= ~dbg;
      dbg_addr_in <= a;
      crd_addr_in <= a;
      @(posedge sys_clk_in);
      dbg_rd_in <= 1'b0;
      crd_req_in <= 1'b0;
      #1;
      while (crd_valid_out !== 1'b1 && dbg_valid_out !== 1'b1 && n < 10) begin
         @(posedge sys_clk_in);
         #1;
         n++;
      end
      check("read latency", 16'(n), 16'(strobe));
      check("read data", rd_data_out, exp);
   endtask

   // Expected {erase, flash write, ram write, violation} for a debug write or erase
   task automatic dwrite(input logic er, input logic [15:0] a, input logic [7:0] d,
                         input logic [3:0] exp);
      wait_ready();
      @(posedge sys_clk_in);
      dbg_wr_in <= ~er;
      dbg_erase_in <= er;
      dbg_addr_in <= a;
      dbg_wdata_in <= d;
      @(posedge sys_clk_in);
      dbg_wr_in <= 1'b0;
      dbg_erase_in <= 1'b0;
      #1;
      check("debug path", {flash_erase_out, flash_wr_out, external_data_ram_wr_out, violation_out}, exp);
      if (exp[3] || exp[2]) begin
         check("debug addr", flash_addr_out, a);
      end
      if (exp[2]) begin
         check("debug data", flash_wdata_out, d);
      end
   endtask

   task automatic s_registers();
      sfr_read(8'hB6, 8'h00);
      check("ext time", flash_ext_time_out, 16'h0000);
      check("lock copy", lock_byte_out, 16'h00FD);
      sfr_write(8'hB6, 8'h12);
      sfr_read(8'hB6, 8'h12);
      check("ext time", flash_ext_time_out, 16'h0001);
      sfr_read(8'h55, 8'h00);
      sfr_write(8'hB6, 8'h02);
   endtask

   task automatic s_routing();
      sfr_write(8'h8F, 8'h00);
      xwrite(16'h0800, 8'h5A, 4'b0010);
      @(posedge sys_clk_in);
      xrd_req_in <= 1'b1;
      xrd_addr_in <= 16'h0800;
      @(posedge sys_clk_in);
      xrd_req_in <= 1'b0;
      #1;
      check("data read to ram", {external_data_ram_rd_out, flash_rd_out}, 16'h0002);
      check("data read addr", external_data_ram_addr_out, 16'h0800);
      sfr_write(8'h8F, 8'h01);
      xwrite(16'h0800, 8'h5A, 4'b0100);
      fread(1'b0, 16'h0800, 8'h5A, 1);
   endtask

   task automatic s_locking();
      xwrite(16'h0100, 8'h00, 4'b0001);
      xwrite(16'h0400, 8'h33, 4'b0100);
      xwrite(16'hFE10, 8'h00, 4'b0001);
      fread(1'b0, 16'h0100, 8'h00, 1);
      fread(1'b1, 16'h03FF, 8'h00, 1);
      @(posedge sys_clk_in);
      core_pc_in <= 16'h0010;
      fread(1'b0, 16'h03FF, 8'hFF, 1);
      @(posedge sys_clk_in);
      core_pc_in <= 16'h2000;
   endtask

   task automatic s_erase();
      sfr_write(8'h8F, 8'h02);
      xwrite(16'h0800, 8'h00, 4'b0010);
      sfr_write(8'h8F, 8'h03);
      sfr_read(8'h8F, 8'h03);
      xwrite(16'h0800, 8'h00, 4'b1000);
      xwrite(16'h0000, 8'h00, 4'b0001);
      sfr_write(8'hB6, 8'h12);
      fread(1'b0, 16'h0800, 8'hFF, 2);
   endtask

   // Debug side ignores the software enables and obeys only the lock
   task automatic s_debug();
      sfr_write(8'h8F, 8'h00);
      dwrite(1'b0, 16'h0C00, 8'hA5, 4'b0100);
      fread(1'b1, 16'h0C00, 8'hA5, 2);
      dwrite(1'b1, 16'h0200, 8'h00, 4'b0001);
      dwrite(1'b0, 16'h0000, 8'h00, 4'b0001);
      dwrite(1'b1, 16'h0C00, 8'h00, 4'b1000);
      fread(1'b1, 16'h0C00, 8'hFF, 2);
   endtask

   // A register write while the clock enable is low must be lost
   task automatic s_freeze();
      @(posedge sys_clk_in);
      clk_en_in <= 1'b0;
      sfr_write(8'hB6, 8'h00);
      repeat (2) @(posedge sys_clk_in);
      clk_en_in <= 1'b1;
      sfr_read(8'hB6, 8'h12);
      check("frozen ext time", flash_ext_time_out, 16'h0001);
   endtask

   // Protected code rewrites the lock byte; a mid-run reset must fetch it again
   task automatic s_reset();
      sfr_write(8'h8F, 8'h01);
      @(posedge sys_clk_in);
      core_pc_in <= 16'h0010;
      xwrite(16'hFFFF, 8'hF9, 4'b0100);
      check("lock copy", lock_byte_out, 16'h00F9);
      @(posedge sys_clk_in);
      core_pc_in <= 16'h2000;
      rst_n_in <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
      #1;
      check("reset lock", lock_byte_out, 16'h00FF);
      check("reset ready", ready_out, 16'h0000);
      @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      wait_ready();
      check("lock reload", lock_byte_out, 16'h00F9);
      sfr_read(8'hB6, 8'h00);
      xwrite(16'h0A00, 8'h00, 4'b0010);
   endtask

   initial begin
      #100us;
      n_fail++;
      end_sim();
   end

   initial begin
      repeat (5) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      wait_ready();
      s_registers();
      s_routing();
      s_locking();
      s_erase();
      s_debug();
      s_freeze();
      s_reset();
      end_sim();
   end
endmodule
